// ---- rtl/sle_pkg.sv ----
// shared constants and types of the serial-in, latched-out expander
// Behaviour
// - clear low zeroes shift stages and cascade
// - shift edge loads input, moves stages on
// - cascade output follows the final stage
// - latch rising edge copies shift into storage
// - no latch edge: storage holds, outputs move only with enable
// - enable high releases all eight outputs
// - eight shift, storage and output stages
// - outputs isolated from shifting until latched
package sle_pkg;

    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int          STAGES      = 8;
    localparam int          BUF_DEPTH   = 2;
    localparam logic [7:0]  SHIFT_RST   = 8'h00;
    localparam logic [7:0]  STORE_RST   = 8'h00;
    localparam logic [7:0]  OE_RELEASED = 8'h00;
    localparam logic [7:0]  PIN_LOW     = 8'h00;

    // ------------------------------------------------------------
    // latch transfer timing
    // ------------------------------------------------------------
    // words in flight across the domains need the pointer sync depth
    localparam logic [3:0]  SETTLE_CYCLES = 4'h3;
    localparam logic [3:0]  SETTLE_RST    = 4'h0;
    localparam logic [3:0]  SETTLE_STEP   = 4'h1;

    typedef enum logic [2:0]
    {
        LT_IDLE  = 3'b001,
        LT_DRAIN = 3'b010,
        LT_COPY  = 3'b100
    } sle_latch_st_t;

endpackage : sle_pkg

// ---- rtl/sle_stream_if.sv ----
// word stream carrier between the buffer and the storage side
interface sle_stream_if #(
    parameter int WIDTH = sle_pkg::STAGES
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sle_stream_if

// ---- rtl/sle_sync.sv ----
// two flip-flop level synchroniser, one per bit
module sle_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] RST   = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RST;
            q      <= RST;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sle_sync

// ---- rtl/sle_word_fifo.sv ----
// small dual-clock word buffer with gray-coded pointers
module sle_word_fifo #(
    parameter int WIDTH = sle_pkg::STAGES,
    parameter int DEPTH = sle_pkg::BUF_DEPTH
) (
    input  wire logic             wr_clk,
    input  wire logic             rd_clk,
    input  wire logic             rst_n,
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  wr_ready,
    sle_stream_if.src             rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_bin_q;
    logic [PW-1:0]    wr_gray_q;
    logic [PW-1:0]    rd_bin_q;
    logic [PW-1:0]    rd_gray_q;
    logic [PW-1:0]    rd_gray_w;
    logic [PW-1:0]    wr_gray_r;
    logic [PW-1:0]    rd_bin_w;
    logic [PW-1:0]    wr_bin_n;
    logic [PW-1:0]    rd_bin_n;

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--)
            b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
        return b;
    endfunction : gray2bin

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    sle_sync #(.WIDTH(PW)) u_rd_ptr_sync (
        .clk   (wr_clk),
        .rst_n (rst_n),
        .d     (rd_gray_q),
        .q     (rd_gray_w)
    );

    assign rd_bin_w = gray2bin(rd_gray_w);
    // full is pessimistic: the read pointer is seen late, never early
    assign wr_ready = !((wr_bin_q[PW-1] != rd_bin_w[PW-1]) &&
                        (wr_bin_q[AW-1:0] == rd_bin_w[AW-1:0]));
    assign wr_bin_n = wr_bin_q + PW'(1);

    always_ff @(posedge wr_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_bin_q  <= '0;
            wr_gray_q <= '0;
        end
        else if (wr_valid && wr_ready)
        begin
            wr_bin_q  <= wr_bin_n;
            wr_gray_q <= wr_bin_n ^ (wr_bin_n >> 1);
        end
    end

    always_ff @(posedge wr_clk)
    begin
        if (wr_valid && wr_ready)
            mem_q[wr_bin_q[AW-1:0]] <= wr_data;
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    sle_sync #(.WIDTH(PW)) u_wr_ptr_sync (
        .clk   (rd_clk),
        .rst_n (rst_n),
        .d     (wr_gray_q),
        .q     (wr_gray_r)
    );

    assign rd.valid = (rd_gray_q != wr_gray_r);
    assign rd.data  = mem_q[rd_bin_q[AW-1:0]];
    assign rd_bin_n = rd_bin_q + PW'(1);

    always_ff @(posedge rd_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_bin_q  <= '0;
            rd_gray_q <= '0;
        end
        else if (rd.valid && rd.ready)
        begin
            rd_bin_q  <= rd_bin_n;
            rd_gray_q <= rd_bin_n ^ (rd_bin_n >> 1);
        end
    end
endmodule : sle_word_fifo

// ---- rtl/sle_expander.sv ----
// serial-in, double-buffered open-drain parallel-out expander
module sle_expander #(
    parameter int WIDTH = sle_pkg::STAGES,
    parameter int DEPTH = sle_pkg::BUF_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             shift_clock,
    input  wire logic             serial_data,
    input  wire logic             shift_clear_n,
    input  wire logic             latch_clock,
    input  wire logic             output_enable_n,
    output logic                  cascade_out,
    output logic                  link_ready,
    input  wire logic [WIDTH-1:0] parallel_outputs_i,
    output logic      [WIDTH-1:0] parallel_outputs_o,
    output logic      [WIDTH-1:0] parallel_outputs_oe
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int LATCH_LO = 1;
    localparam int LATCH_HI = 16;
    localparam int            CW       = $clog2(WIDTH);
    localparam logic [CW-1:0] CNT_LAST = CW'(WIDTH - 1);
    localparam logic [CW-1:0] CNT_STEP = CW'(1);

    logic [WIDTH-1:0]      shift_stage_q;
    logic [WIDTH-1:0]      shift_stage_d;
    logic                  link_clr_n;
    logic                  clear_s;
    logic                  latch_s;
    logic                  latch_d1_q;
    logic                  latch_rise;
    logic                  oe_n_s;
    logic [WIDTH-1:0]      mirror_q;
    logic [WIDTH-1:0]      storage_stage_q;
    logic [3:0]            settle_q;
    logic                  pop;
    logic [CW-1:0]         bit_cnt_q;
    logic                  word_done;
    sle_pkg::sle_latch_st_t state_q;
    sle_pkg::sle_latch_st_t state_d;

    sle_stream_if #(.WIDTH(WIDTH)) word_if ();

    // ------------------------------------------------------------
    // link side: shift stages on the shift clock
    // ------------------------------------------------------------
    // clear acts without the shift clock, so it joins the async reset
    assign link_clr_n    = rst_n & shift_clear_n;
    assign shift_stage_d = {shift_stage_q[WIDTH-2:0], serial_data};

    always_ff @(posedge shift_clock or negedge link_clr_n)
    begin
        if (!link_clr_n)
            shift_stage_q <= sle_pkg::SHIFT_RST;
        else
            shift_stage_q <= shift_stage_d;
    end

    assign cascade_out = shift_stage_q[WIDTH-1];

    // bit position within the current byte, cleared with the stages
    always_ff @(posedge shift_clock or negedge link_clr_n)
    begin
        if (!link_clr_n)
            bit_cnt_q <= '0;
        else if (word_done)
            bit_cnt_q <= '0;
        else
            bit_cnt_q <= bit_cnt_q + CNT_STEP;
    end

    assign word_done = (bit_cnt_q == CNT_LAST);

    // ------------------------------------------------------------
    // crossing: each completed shift byte goes through the buffer
    // ------------------------------------------------------------
    // one word per full byte: the write side sees the returned
    // pointer only on shift edges, so a word per edge would fill
    // both entries; limitation: a frame shorter than a byte is
    // not mirrored until it completes
    sle_word_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_buf (
        .wr_clk   (shift_clock),
        .rd_clk   (clk_sys),
        .rst_n    (rst_n),
        .wr_valid (shift_clear_n && word_done),
        .wr_data  (shift_stage_d),
        .wr_ready (link_ready),
        .rd       (word_if.src)
    );

    // ------------------------------------------------------------
    // pin synchronisers into the system clock
    // ------------------------------------------------------------
    sle_sync #(.WIDTH(1), .RST(1'b1)) u_clear_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (shift_clear_n),
        .q     (clear_s)
    );

    sle_sync #(.WIDTH(1), .RST(1'b0)) u_latch_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (latch_clock),
        .q     (latch_s)
    );

    sle_sync #(.WIDTH(1), .RST(1'b1)) u_oe_sync (
        .clk   (clk_sys),
        .rst_n (rst_n),
        .d     (output_enable_n),
        .q     (oe_n_s)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            latch_d1_q <= 1'b0;
        else
            latch_d1_q <= latch_s;
    end

    assign latch_rise = latch_s && !latch_d1_q;

    // ------------------------------------------------------------
    // mirror of the shift stages in the system domain
    // ------------------------------------------------------------
    // the buffer is not popped in the copy cycle, so a copy never
    // sees a half-applied word
    assign word_if.ready = (state_q != sle_pkg::LT_COPY);
    assign pop           = word_if.valid && word_if.ready;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            mirror_q <= sle_pkg::SHIFT_RST;
        else if (!clear_s)
            mirror_q <= sle_pkg::SHIFT_RST;
        else if (pop)
            mirror_q <= word_if.data;
        // otherwise the mirror holds, like the shift stages
    end

    // ------------------------------------------------------------
    // latch transfer sequencing
    // ------------------------------------------------------------
    // a second latch edge inside the drain window merges into the first
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            sle_pkg::LT_IDLE:
            begin
                if (latch_rise)
                    state_d = sle_pkg::LT_DRAIN;
            end
            sle_pkg::LT_DRAIN:
            begin
                if (settle_q >= sle_pkg::SETTLE_CYCLES && !word_if.valid)
                    state_d = sle_pkg::LT_COPY;
            end
            sle_pkg::LT_COPY:
            begin
                state_d = sle_pkg::LT_IDLE;
            end
            default:
            begin
                state_d = sle_pkg::LT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= sle_pkg::LT_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            settle_q <= sle_pkg::SETTLE_RST;
        else if (state_q != sle_pkg::LT_DRAIN)
            settle_q <= sle_pkg::SETTLE_RST;
        else if (settle_q < sle_pkg::SETTLE_CYCLES)
            settle_q <= settle_q + sle_pkg::SETTLE_STEP;
    end

    // ------------------------------------------------------------
    // storage stages and open-drain outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            storage_stage_q <= sle_pkg::STORE_RST;
        else if (state_q == sle_pkg::LT_COPY)
            storage_stage_q <= mirror_q;
        // no copy: storage holds whatever the shift side does
    end

    // drive level is always low; only the enable moves
    assign parallel_outputs_o = sle_pkg::PIN_LOW;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            parallel_outputs_oe <= sle_pkg::OE_RELEASED;
        else if (oe_n_s)
            parallel_outputs_oe <= sle_pkg::OE_RELEASED;
        else
            parallel_outputs_oe <= ~storage_stage_q;
    end

    // ------------------------------------------------------------
    // assertions: link domain
    // ------------------------------------------------------------
    property p_clear_zero;
        @(posedge shift_clock) disable iff (!rst_n)
        !shift_clear_n |-> (shift_stage_q == '0) && !cascade_out;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("shift stages not zero under clear");

    property p_shift_move;
        @(posedge shift_clock) disable iff (!rst_n || !shift_clear_n)
        $past(shift_clear_n) |->
            shift_stage_q == {$past(shift_stage_q[WIDTH-2:0]), $past(serial_data)};
    endproperty
    a_shift_move: assert property (p_shift_move)
        else $error("shift stages did not move by one");

    property p_cascade;
        @(posedge shift_clock) disable iff (!rst_n || !shift_clear_n)
        $past(shift_clear_n) |-> cascade_out == $past(shift_stage_q[WIDTH-2]);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade output missed the seventh stage");

    // ------------------------------------------------------------
    // assertions: system domain
    // ------------------------------------------------------------
    property p_mirror_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (clear_s && !pop) |=> $stable(mirror_q);
    endproperty
    a_mirror_hold: assert property (p_mirror_hold)
        else $error("shift word changed without a shift");

    sequence s_latch_req;
        (state_q == sle_pkg::LT_IDLE) && latch_rise;
    endsequence

    sequence s_copy_done;
        (state_q == sle_pkg::LT_DRAIN) ##[LATCH_LO:LATCH_HI] (state_q == sle_pkg::LT_COPY);
    endsequence

    property p_latch_bound;
        @(posedge clk_sys) disable iff (!rst_n)
        s_latch_req |=> s_copy_done;
    endproperty
    a_latch_bound: assert property (p_latch_bound)
        else $error("latch edge not transferred in time");

    property p_copy_value;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q == sle_pkg::LT_COPY) |=> storage_stage_q == $past(mirror_q);
    endproperty
    a_copy_value: assert property (p_copy_value)
        else $error("storage does not match shifted word");

    property p_storage_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_q != sle_pkg::LT_COPY) |=> $stable(storage_stage_q);
    endproperty
    a_storage_hold: assert property (p_storage_hold)
        else $error("storage changed without latch edge");

    property p_isolated;
        @(posedge clk_sys) disable iff (!rst_n)
        (pop && state_q == sle_pkg::LT_DRAIN) ##1 (state_q != sle_pkg::LT_COPY)
            |=> $stable(storage_stage_q);
    endproperty
    a_isolated: assert property (p_isolated)
        else $error("shifting reached the storage stages");

    property p_hiz;
        @(posedge clk_sys) disable iff (!rst_n)
        oe_n_s [*2] |-> parallel_outputs_oe == '0;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("outputs driven while disabled");

    property p_open_drain;
        @(posedge clk_sys) disable iff (!rst_n)
        !oe_n_s |=> parallel_outputs_oe == ~$past(storage_stage_q);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("output enable does not follow stored zeros");

    property p_width;
        @(posedge clk_sys) disable iff (!rst_n)
        $countones(parallel_outputs_oe) <= WIDTH && WIDTH == sle_pkg::STAGES;
    endproperty
    a_width: assert property (p_width)
        else $error("stage count differs from eight");

endmodule : sle_expander

// ---- test/sle_host_model.sv ----
// host-side model: serial frames, latch pulses, clear and enable lines
module sle_host_model (
    input  wire logic clk_sys,
    input  wire logic clear_req_n,
    input  wire logic enable_req_n,
    input  wire logic latch_req,
    output logic      shift_clock,
    output logic      serial_data,
    output logic      shift_clear_n,
    output logic      latch_clock,
    output logic      output_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial
    begin
        shift_clock     = 1'b0;
        serial_data     = 1'b0;
    end

    // ------------------------------------------------------------
    // link side: clock only runs within a frame
    // ------------------------------------------------------------
    task automatic shift_bit(input logic b);
        serial_data = b;
        #15 shift_clock = 1'b1;
        // hold time over: line no longer shows the bit
        #7 serial_data = ~b;
        #8 shift_clock = 1'b0;
    endtask : shift_bit

    // ------------------------------------------------------------
    // system side lines, changed just after a clk_sys edge
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        shift_clear_n   <= clear_req_n;
        // latch is the only line owned by this device alone
        latch_clock     <= latch_req;
        output_enable_n <= enable_req_n;
    end
endmodule : sle_host_model

// ---- test/testbench.sv ----
// self-checking bench of the serial-in, latched-out expander
`define CHECK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys;
    logic       rst_n;
    logic       shift_clock;
    logic       serial_data;
    logic       shift_clear_n;
    logic       latch_clock;
    logic       output_enable_n;
    logic       clear_req_n;
    logic       enable_req_n;
    logic       latch_req;
    logic       cascade_out;
    logic       link_ready;
    logic [7:0] pin_level;
    logic [7:0] parallel_outputs_o;
    logic [7:0] parallel_outputs_oe;
    int         bad_count;
    int         total_checks;
    integer     seed;
    logic [7:0] exp_q[$];
    logic [7:0] shadow_q;
    logic [7:0] seen_oe_q;
    logic [7:0] exp_oe;
    logic [7:0] stored;
    logic [7:0] word;
    logic [7:0] table_w[5];

    // open drain with pull-up: low only where driven
    assign pin_level = ~parallel_outputs_oe | parallel_outputs_o;

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    sle_expander sle_expander_inst (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .shift_clock         (shift_clock),
        .serial_data         (serial_data),
        .shift_clear_n       (shift_clear_n),
        .latch_clock         (latch_clock),
        .output_enable_n     (output_enable_n),
        .cascade_out         (cascade_out),
        .link_ready          (link_ready),
        .parallel_outputs_i  (pin_level),
        .parallel_outputs_o  (parallel_outputs_o),
        .parallel_outputs_oe (parallel_outputs_oe)
    );

    sle_host_model host_inst (
        .clk_sys         (clk_sys),
        .clear_req_n     (clear_req_n),
        .enable_req_n    (enable_req_n),
        .latch_req       (latch_req),
        .shift_clock     (shift_clock),
        .serial_data     (serial_data),
        .shift_clear_n   (shift_clear_n),
        .latch_clock     (latch_clock),
        .output_enable_n (output_enable_n)
    );

    // ------------------------------------------------------------
    // closing
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // driver helpers
    // ------------------------------------------------------------
    // last-output bit goes first, so it ends at bit 7
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            host_inst.shift_bit(b[i]);
            shadow_q = {shadow_q[6:0], b[i]};
            `CHECK("cascade_out", shadow_q[7], cascade_out)
        end
    endtask : send_byte

    task automatic pulse_latch();
        @(posedge clk_sys);
        latch_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        latch_req <= 1'b0;
        // long gap covers the worst transfer time
        repeat (24) @(posedge clk_sys);
    endtask : pulse_latch

    task automatic set_clear_n(input logic v);
        @(posedge clk_sys);
        clear_req_n <= v;
        repeat (5) @(posedge clk_sys);
    endtask : set_clear_n

    task automatic set_enable_n(input logic v);
        @(posedge clk_sys);
        enable_req_n <= v;
        repeat (5) @(posedge clk_sys);
    endtask : set_enable_n

    // ------------------------------------------------------------
    // monitor: any change of the drive enables consumes one note
    // ------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            seen_oe_q <= 8'h00;
        else if (parallel_outputs_oe !== seen_oe_q)
        begin
            seen_oe_q <= parallel_outputs_oe;
            // unexpected change finds no note and fails
            exp_oe = (exp_q.size() > 0) ? exp_q.pop_front() : ~parallel_outputs_oe;
            `CHECK("parallel_outputs_oe", exp_oe, parallel_outputs_oe)
            `CHECK("parallel_outputs_o", 8'h00, parallel_outputs_o)
        end
    end

    initial
    begin
        #100000;
        bad_count++;
        $display("watchdog expired");
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hd5cf;
        rst_n = 1'b0;
        clear_req_n = 1'b1;
        enable_req_n = 1'b0;
        latch_req = 1'b0;
        bad_count = 0;
        total_checks = 0;
        shadow_q = 8'h00;
        stored = 8'h00;
        table_w = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h3c};
        exp_q.push_back(8'hff);
        repeat (2) @(posedge clk_sys);
        `CHECK("reset oe", 8'h00, parallel_outputs_oe)
        `CHECK("reset cascade_out", 1'b0, cascade_out)
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        // single-bit words, random words, then a fixed one
        for (int n = 0; n < 5; n++)
        begin
            word = (n == 2 || n == 3) ? 8'($random(seed)) : table_w[n];
            if (word == stored)
                word = ~word;
            exp_q.push_back(~word);
            send_byte(word);
            `CHECK("link_ready", 1'b1, link_ready)
            pulse_latch();
            stored = word;
        end
        // two words back to back: only the second is latched
        send_byte(8'hc3);
        send_byte(8'h96);
        exp_q.push_back(8'h69);
        pulse_latch();
        // clear after a whole byte, with a shift edge while held
        send_byte(8'h5a);
        set_clear_n(1'b0);
        `CHECK("cascade_out clear", 1'b0, cascade_out)
        host_inst.shift_bit(1'b1);
        `CHECK("cascade_out held", 1'b0, cascade_out)
        set_clear_n(1'b1);
        repeat (10) @(posedge clk_sys);
        shadow_q = 8'h00;
        exp_q.push_back(8'hff);
        pulse_latch();
        // outputs released, a latch meanwhile, enable again
        exp_q.push_back(8'h00);
        set_enable_n(1'b1);
        send_byte(8'ha5);
        pulse_latch();
        exp_q.push_back(8'h5a);
        set_enable_n(1'b0);
        repeat (10) @(posedge clk_sys);
        // repeat latch without shifting changes nothing
        pulse_latch();
        repeat (10) @(posedge clk_sys);
        `CHECK("notes left", 0, exp_q.size())
        end_of_test();
    end
endmodule : testbench
